// [logic/urx_receiver_top.sv]
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "urx_cfg.svh"
module urx_receiver_top
    import urx_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    // Register port
    input  wire logic [7:0] addr_in,
    input  wire urx_word_t  wr_data_in,
    input  wire logic       wr_en_in,
    input  wire logic       rd_en_in,
    output urx_word_t       rd_data_out,
    // Serial line
    input  wire logic       rx_pin_in,
    // Transmit hand-off
    output logic [8:0]      tx_char_out,
    output logic            tx_load_out,
    // Interrupt
    output logic            irq_out
);
    // Baud generator state
    urx_word_t  div_cnt_r,  div_cnt_nxt;
    logic       tick_r,     tick_nxt;
    // Line synchroniser
    logic       sync1_r, sync2_r, sync3_r;
    logic       rx_f_r,     rx_f_nxt;
    // Receiver state
    urx_state_e state_r,    state_nxt;
    logic [4:0] os_cnt_r,   os_cnt_nxt;
    logic [3:0] bit_cnt_r,  bit_cnt_nxt;
    logic [8:0] shift_r,    shift_nxt;
    logic       done_w;
    logic       framing_error_flag_w;
    // Queue and status
    logic [1:0] wr_ptr_r,   wr_ptr_nxt;
    logic [1:0] rd_ptr_r,   rd_ptr_nxt;
    logic [2:0] count_r,    count_nxt;
    logic       ovr_r,      ovr_nxt;
    logic       match_r,    match_nxt;
    logic [`URX_EV_N-1:0] istat_r, istat_nxt;
    logic [`URX_EV_N-1:0] ev_w;
    logic       push_w, pop_w, flush_w, ovr_ev_w, hit_w, accept_w;
    urx_entry_t head_w, entry_w;
    // Software registers
    logic [1:0] isel_r,     isel_nxt;
    logic       address_detect_enable_r,    address_detect_enable_nxt;
    urx_word_t  brg_r,      brg_nxt;
    urx_word_t  admd_r,     admd_nxt;
    logic [2:0] mode_r,     mode_nxt;
    logic [`URX_EV_N-1:0] ien_r, ien_nxt;
    logic [8:0] tx_r,       tx_nxt;
    logic       txld_r,     txld_nxt;
    urx_word_t  rdat_r,     rdat_nxt;
    logic       irq_r,      irq_nxt;
    // Decoded configuration
    logic [1:0] parity_data_select_w;
    logic       hs_w, nine_w, par_on_w, addr_mode_w, parity_error_flag_w;
    logic [4:0] os_last_w, os_mid_w;
    logic [3:0] bit_last_w;
    logic [8:0] data_w;
    logic       wr_sta_w;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    // Configuration decode
    assign hs_w        = mode_r[`URX_MODE_HS];
    assign parity_data_select_w     = mode_r[2:1];
    assign nine_w      = (parity_data_select_w == `URX_PD_9N);
    assign par_on_w    = parity_data_select_w[1] ^ parity_data_select_w[0];
    assign os_last_w   = hs_w ? `URX_OS_HI_LAST : `URX_OS_STD_LAST;
    assign os_mid_w    = hs_w ? `URX_OS_HI_MID : `URX_OS_STD_MID;
    assign bit_last_w  = (nine_w || par_on_w) ? 4'h8 : 4'h7;
    assign addr_mode_w = address_detect_enable_r && nine_w;

    // Baud tick every divisor plus one clocks
    always_comb begin
        div_cnt_nxt = div_cnt_r + 16'h0001;
        tick_nxt    = 1'b0;
        if (div_cnt_r >= brg_r) begin
            div_cnt_nxt = 16'h0000;
            tick_nxt    = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            div_cnt_r <= 16'h0000;
            tick_r    <= 1'b0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            tick_r    <= tick_nxt;
        end
    end

    // Line level accepted once second and third stages agree
    assign rx_f_nxt = (sync2_r == sync3_r) ? sync3_r : rx_f_r;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            sync3_r <= 1'b1;
            rx_f_r  <= 1'b1;
        end else begin
            sync1_r <= rx_pin_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            rx_f_r  <= rx_f_nxt;
        end
    end

    // Receive shift sequencer, LSB first, samples at mid-bit
    always_comb begin
        state_nxt   = state_r;
        os_cnt_nxt  = os_cnt_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt   = shift_r;
        done_w      = 1'b0;
        framing_error_flag_w      = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (!rx_f_r) begin
                    state_nxt  = ST_START;
                    os_cnt_nxt = 5'h00;
                end
            end
            ST_START: begin
                if (tick_r) begin
                    if (os_cnt_r == os_mid_w) begin
                        state_nxt   = rx_f_r ? ST_IDLE : ST_DATA;
                        os_cnt_nxt  = 5'h00;
                        bit_cnt_nxt = 4'h0;
                    end else begin
                        os_cnt_nxt = os_cnt_r + 5'h01;
                    end
                end
            end
            ST_DATA: begin
                if (tick_r) begin
                    if (os_cnt_r == os_last_w) begin
                        os_cnt_nxt  = 5'h00;
                        shift_nxt   = {rx_f_r, shift_r[8:1]};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                        if (bit_cnt_r == bit_last_w) begin
                            state_nxt = ST_STOP;
                        end
                    end else begin
                        os_cnt_nxt = os_cnt_r + 5'h01;
                    end
                end
            end
            ST_STOP: begin
                if (tick_r) begin
                    if (os_cnt_r == os_last_w) begin
                        done_w    = 1'b1;
                        framing_error_flag_w    = !rx_f_r;
                        state_nxt = ST_IDLE;
                    end else begin
                        os_cnt_nxt = os_cnt_r + 5'h01;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (flush_w) begin
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_r   <= ST_IDLE;
            os_cnt_r  <= 5'h00;
            bit_cnt_r <= 4'h0;
            shift_r   <= 9'h000;
        end else begin
            state_r   <= state_nxt;
            os_cnt_r  <= os_cnt_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r   <= shift_nxt;
        end
    end

    // Character assembly and parity check
    always_comb begin
        if (nine_w) begin
            data_w = shift_r;
        end else if (par_on_w) begin
            data_w = {1'b0, shift_r[7:0]};
        end else begin
            data_w = {1'b0, shift_r[8:1]};
        end
    end
    assign parity_error_flag_w  = par_on_w && ((^shift_r) != parity_data_select_w[1]);
    assign entry_w = {framing_error_flag_w, parity_error_flag_w, data_w};

    // Masked address compare and acceptance
    assign hit_w = ((data_w[7:0] ^ admd_r[7:0]) & admd_r[15:8]) == 8'h00;
    always_comb begin
        match_nxt = match_r;
        accept_w  = 1'b1;
        if (addr_mode_w) begin
            if (data_w[8]) begin
                accept_w = hit_w;
                if (done_w) begin
                    match_nxt = hit_w;
                end
            end else begin
                accept_w = match_r;
            end
        end else begin
            match_nxt = 1'b0;
        end
    end

    // Queue pointers, overrun, interrupt status
    assign wr_sta_w = wr_en_in && (addr_in == `URX_OFF_STA);
    assign pop_w    = rd_en_in && (addr_in == `URX_OFF_RXD) && (count_r != 3'h0);
    assign ovr_ev_w = done_w && accept_w && (count_r == `URX_Q_FULL) && !pop_w;
    assign push_w   = done_w && accept_w && !ovr_ev_w && !flush_w;
    assign flush_w  = wr_sta_w && !wr_data_in[`URX_STA_OVR] && ovr_r && !ovr_ev_w;

    always_comb begin
        wr_ptr_nxt = wr_ptr_r + {1'b0, push_w};
        rd_ptr_nxt = rd_ptr_r + {1'b0, pop_w};
        count_nxt  = count_r + {2'b00, push_w} - {2'b00, pop_w};
        ovr_nxt    = ovr_r;
        if (ovr_ev_w) begin
            ovr_nxt = 1'b1;
        end else if (flush_w) begin
            ovr_nxt    = 1'b0;
            wr_ptr_nxt = 2'b00;
            rd_ptr_nxt = 2'b00;
            count_nxt  = 3'h0;
        end
        ev_w = '0;
        case (isel_r)
            `URX_IS_FULL: ev_w[`URX_EV_RX] = push_w && (count_nxt == `URX_Q_FULL);
            `URX_IS_3Q:   ev_w[`URX_EV_RX] = push_w && (count_nxt == `URX_Q_3Q);
            default:      ev_w[`URX_EV_RX] = push_w;
        endcase
        ev_w[`URX_EV_OVR] = ovr_ev_w;
        ev_w[`URX_EV_PE]  = push_w && parity_error_flag_w;
        ev_w[`URX_EV_FE]  = push_w && framing_error_flag_w;
        ev_w[`URX_EV_ADR] = done_w && addr_mode_w && data_w[8] && hit_w;
        istat_nxt = istat_r;
        if (wr_en_in && (addr_in == `URX_OFF_ICLR)) begin
            istat_nxt = istat_r & ~wr_data_in[`URX_EV_N-1:0];
        end
        istat_nxt = istat_nxt | ev_w;                                     // set beats clear
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wr_ptr_r <= 2'b00;
            rd_ptr_r <= 2'b00;
            count_r  <= 3'h0;
            ovr_r    <= 1'b0;
            match_r  <= 1'b0;
            istat_r  <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
            ovr_r    <= ovr_nxt;
            match_r  <= flush_w ? 1'b0 : match_nxt;
            istat_r  <= istat_nxt;
        end
    end

    // Four-entry receive queue, head read out of a register
    urx_queue_mem u_queue (
        .clk_in      (clk_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (push_w),
        .wr_addr_in  (wr_ptr_r),
        .wr_data_in  (entry_w),
        .rd_addr_in  (rd_ptr_nxt),
        .rd_data_out (head_w)
    );

    // Register writes and read-data mux
    always_comb begin
        isel_nxt  = isel_r;
        address_detect_enable_nxt = address_detect_enable_r;
        brg_nxt   = brg_r;
        admd_nxt  = admd_r;
        mode_nxt  = mode_r;
        ien_nxt   = ien_r;
        tx_nxt    = tx_r;
        txld_nxt  = 1'b0;
        rdat_nxt  = 16'h0000;
        if (wr_en_in) begin
            case (addr_in)
                `URX_OFF_STA: begin
                    isel_nxt  = wr_data_in[7:6];
                    address_detect_enable_nxt = wr_data_in[`URX_STA_ADDRESS_DETECT_ENABLE];
                end
                `URX_OFF_TXD: begin
                    tx_nxt   = wr_data_in[8:0];
                    txld_nxt = 1'b1;
                end
                `URX_OFF_BRG:  brg_nxt  = wr_data_in;
                `URX_OFF_ADMD: admd_nxt = wr_data_in;
                `URX_OFF_MODE: mode_nxt = wr_data_in[2:0];
                `URX_OFF_IEN:  ien_nxt  = wr_data_in[`URX_EV_N-1:0];
                default: begin
                end
            endcase
        end
        if (rd_en_in) begin
            case (addr_in)
                `URX_OFF_STA: rdat_nxt = {8'h00, isel_r, address_detect_enable_r,
                                          state_r == ST_IDLE,
                                          head_w[9] && (count_r != 3'h0),
                                          head_w[10] && (count_r != 3'h0),
                                          ovr_r,
                                          count_r != 3'h0};
                `URX_OFF_RXD:   rdat_nxt = (count_r != 3'h0) ? {7'h00, head_w[8:0]} : 16'h0000;
                `URX_OFF_BRG:   rdat_nxt = brg_r;
                `URX_OFF_ADMD:  rdat_nxt = admd_r;
                `URX_OFF_MODE:  rdat_nxt = {13'h0000, mode_r};
                `URX_OFF_ISTAT: rdat_nxt = {11'h000, istat_r};
                `URX_OFF_IEN:   rdat_nxt = {11'h000, ien_r};
                default:        rdat_nxt = 16'h0000;
            endcase
        end
        irq_nxt = |(istat_nxt & ien_nxt);
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            isel_r  <= 2'b00;
            address_detect_enable_r <= 1'b0;
            brg_r   <= 16'h0000;
            admd_r  <= 16'h0000;
            mode_r  <= 3'h0;
            ien_r   <= '0;
            tx_r    <= 9'h000;
            txld_r  <= 1'b0;
            rdat_r  <= 16'h0000;
            irq_r   <= 1'b0;
        end else begin
            isel_r  <= isel_nxt;
            address_detect_enable_r <= address_detect_enable_nxt;
            brg_r   <= brg_nxt;
            admd_r  <= admd_nxt;
            mode_r  <= mode_nxt;
            ien_r   <= ien_nxt;
            tx_r    <= tx_nxt;
            txld_r  <= txld_nxt;
            rdat_r  <= rdat_nxt;
            irq_r   <= irq_nxt;
        end
    end

    assign rd_data_out = rdat_r;
    assign tx_char_out = tx_r;
    assign tx_load_out = txld_r;
    assign irq_out     = irq_r;

    // Checks
    AST_FULL_IRQ: assert property (push_w && isel_r == 2'b11 && count_r == 3'h3 && !pop_w |=> istat_r[0])
        else $error("full-queue interrupt missing");
    AST_3Q_IRQ: assert property (push_w && isel_r == 2'b10 && count_r == 3'h2 && !pop_w |=> istat_r[0])
        else $error("three-quarter interrupt missing");
    AST_ANY_IRQ: assert property (push_w && !isel_r[1] |=> istat_r[0] && count_r != 3'h0)
        else $error("per-character interrupt missing");
    AST_IDLE_FLAG: assert property (rd_en_in && addr_in == 8'h00 && state_r != ST_IDLE |=> !rd_data_out[4])
        else $error("idle flag set while receiving");
    AST_OVR_SET: assert property (done_w && accept_w && count_r == 3'h4 && !pop_w |=> ovr_r ##1 (ovr_r || $past(flush_w)))
        else $error("overrun not flagged");
    AST_FLUSH: assert property (flush_w |=> count_r == 3'h0 && state_r == ST_IDLE && !ovr_r)
        else $error("overrun clear did not flush");
    AST_DA_FLAG: assert property (rd_en_in && addr_in == 8'h00 |=> rd_data_out[0] == ($past(count_r) != 3'h0))
        else $error("data-available flag wrong");
    AST_RXD_UPPER: assert property (rd_en_in && addr_in == 8'h04 |=> rd_data_out[15:9] == 7'h00)
        else $error("receive data upper bits not zero");
    AST_ADDR_DROP: assert property (done_w && addr_mode_w && data_w[8] && !hit_w |-> !push_w ##1 !match_r)
        else $error("mismatched address accepted");
    AST_DATA_DROP: assert property (done_w && addr_mode_w && !data_w[8] && !match_r |-> !push_w)
        else $error("data accepted without address match");
endmodule
`default_nettype wire

// [logic/urx_cfg.svh]
`ifndef URX_CFG_SVH
`define URX_CFG_SVH
// Register byte offsets
`define URX_OFF_STA    8'h00
`define URX_OFF_RXD    8'h04
`define URX_OFF_TXD    8'h08
`define URX_OFF_BRG    8'h0C
`define URX_OFF_ADMD   8'h10
`define URX_OFF_MODE   8'h14
`define URX_OFF_ISTAT  8'h18
`define URX_OFF_ICLR   8'h1C
`define URX_OFF_IEN    8'h20
// Status register bit positions
`define URX_STA_DA     0
`define URX_STA_OVR    1
`define URX_STA_FE     2
`define URX_STA_PE     3
`define URX_STA_IDLE   4
`define URX_STA_ADDRESS_DETECT_ENABLE  5
// Mode register bit positions
`define URX_MODE_HS    0
// Interrupt event bit positions
`define URX_EV_RX      0
`define URX_EV_OVR     1
`define URX_EV_PE      2
`define URX_EV_FE      3
`define URX_EV_ADR     4
`define URX_EV_N       5
// Parity and data selector codes
`define URX_PD_9N      2'b11
`define URX_PD_8O      2'b10
// Receive interrupt selector codes
`define URX_IS_FULL    2'b11
`define URX_IS_3Q      2'b10
// Oversampling: last tick and mid-bit tick per bit
`define URX_OS_STD_LAST 5'h0F
`define URX_OS_HI_LAST  5'h03
`define URX_OS_STD_MID  5'h07
`define URX_OS_HI_MID   5'h01
// Queue depth and levels
`define URX_Q_FULL     3'h4
`define URX_Q_3Q       3'h3
`endif

// [logic/urx_pkg.sv]
`default_nettype none
package urx_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_START = 4'b0010,
        ST_DATA  = 4'b0100,
        ST_STOP  = 4'b1000
    } urx_state_e;
    typedef logic [15:0] urx_word_t;
    // Queue entry: framing error, parity error, 9 data bits
    typedef logic [10:0] urx_entry_t;
endpackage
`default_nettype wire

// [logic/urx_queue_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module urx_queue_mem
    import urx_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    // Write side
    input  wire logic       wr_en_in,
    input  wire logic [1:0] wr_addr_in,
    input  wire urx_entry_t wr_data_in,
    // Read side
    input  wire logic [1:0] rd_addr_in,
    output urx_entry_t      rd_data_out
);
    urx_entry_t mem_r [4];
    urx_entry_t rd_r;
    urx_entry_t rd_nxt;

    // Registered read with write bypass so the head is never stale
    always_comb begin
        rd_nxt = mem_r[rd_addr_in];
        if (wr_en_in && (wr_addr_in == rd_addr_in)) begin
            rd_nxt = wr_data_in;
        end
    end

    // Storage and read register
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
        if (sys_rst_in) begin
            rd_r <= 11'h000;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    assign rd_data_out = rd_r;
endmodule
`default_nettype wire

// [verification/urx_line_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Remote serial sender: idle high, start low, LSB first, one stop bit
module urx_line_model (
    // Clock
    input  wire logic clk_in,
    // Serial line
    output logic      line_out
);
    initial line_out = 1'b1;

    // Sends one frame; par 0 none, 1 even, 2 odd; faults flip parity or stop
    task automatic send(input logic [8:0] d, input int nbits, input int par, input logic bad_par,
                        input logic bad_stop, input int cpb);
        logic [13:0] bits;
        int          n;
        bits    = '1;
        bits[0] = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            bits[1 + i] = d[i];
        end
        n = nbits + 1;
        if (par != 0) begin
            bits[n] = (^d[7:0]) ^ (par == 2) ^ bad_par;
            n++;
        end
        bits[n] = ~bad_stop;
        // Each bit lasts cpb clocks; two idle bits close the frame
        for (int i = 0; i <= n + 2; i++) begin
            @(posedge clk_in);
            line_out <= bits[i];
            repeat (cpb - 1) @(posedge clk_in);
        end
    endtask
endmodule
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "urx_cfg.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top
    import urx_pkg::*;
;
    logic       clk_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    logic       wr_en_in = 1'b0;
    logic       rd_en_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    urx_word_t  wr_data_in = 16'h0000;
    urx_word_t  rd_data_out;
    urx_word_t  rdv;
    urx_word_t  v;
    logic [8:0] tx_char_out;
    logic       tx_load_out;
    logic       irq_out;
    wire        rx_pin;
    int         n_errors = 0;
    int         checked = 0;
    // Bench model state
    urx_entry_t q[$];
    logic [1:0] sel = 2'b00;
    logic [1:0] pd = 2'b00;
    logic       address_detect_enable = 1'b0;
    logic       hs = 1'b0;
    logic       ovr = 1'b0;
    logic       matched = 1'b0;
    logic [4:0] istat = 5'h00;
    logic [4:0] ien = 5'h00;
    logic [7:0] mask = 8'h00;
    logic [7:0] maddr = 8'h00;
    int         baud_divisor_value = 0;
    logic [8:0] adr_seq [6] = '{9'h012, 9'h1B0, 9'h1A3, 9'h055, 9'h1C0, 9'h066};

    urx_receiver_top i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
        .rx_pin_in(rx_pin), .tx_char_out(tx_char_out), .tx_load_out(tx_load_out), .irq_out(irq_out));
    urx_line_model i_line (.clk_in(clk_in), .line_out(rx_pin));

    // Clock at 250 MHz
    initial forever #2 clk_in = ~clk_in;

    // Register bus cycles
    task automatic wr(input logic [7:0] a, input urx_word_t d);
        @(posedge clk_in);
        wr_en_in   <= 1'b1;
        addr_in    <= a;
        wr_data_in <= d;
        @(posedge clk_in);
        wr_en_in   <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        rd_en_in <= 1'b1;
        addr_in  <= a;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1 rdv = rd_data_out;
    endtask

    // Expected status word from the model
    function automatic urx_word_t sta_exp();
        urx_entry_t h = (q.size() > 0) ? q[0] : '0;
        return {8'h00, sel, address_detect_enable, 1'b1, h[9], h[10], ovr, q.size() > 0};
    endfunction

    // Status write; a zero over a set overrun flushes the queue, overrun flag and receiver
    task automatic wsta();
        wr(`URX_OFF_STA, {8'h00, sel, address_detect_enable, 5'h00});
        if (ovr) begin
            ovr = 1'b0;
            q.delete();
        end
    endtask
    task automatic wmode(input logic h, input logic [1:0] p);
        hs = h;
        pd = p;
        wr(`URX_OFF_MODE, {13'h0000, p, h});
    endtask
    task automatic chk_irq();
        rd(`URX_OFF_ISTAT);
        `CHK("istat", {11'h000, istat}, rdv)
        `CHK("irq", |(istat & ien), irq_out)
    endtask

    // Sends one character and updates the model; err 1 bad parity, 2 bad stop
    task automatic tx(input logic [8:0] d, input int err);
        logic pe;
        logic fe;
        logic keep;
        int   par;
        int   cpb;
        par = (pd == `URX_PD_8O) ? 2 : (pd == 2'b01) ? 1 : 0;
        cpb = (baud_divisor_value + 1) * (hs ? 4 : 16);
        if (pd != `URX_PD_9N) d[8] = 1'b0;
        pe = (err == 1) && (par != 0);
        fe = (err == 2);
        fork
            i_line.send(d, (pd == `URX_PD_9N) ? 9 : 8, par, err == 1, fe, cpb);
            begin
                repeat (cpb * 3) @(posedge clk_in);
                rd(`URX_OFF_STA);
                `CHK("idle", 1'b0, rdv[4])
            end
        join
        keep = 1'b1;
        if (address_detect_enable && pd == `URX_PD_9N) begin
            if (d[8]) begin
                matched  = ((d[7:0] ^ maddr) & mask) == 8'h00;
                istat[4] = istat[4] | matched;
            end
            keep = matched;
        end
        if (keep && q.size() == 4) begin
            ovr      = 1'b1;
            istat[1] = 1'b1;
        end else if (keep) begin
            q.push_back({fe, pe, d});
            if (sel < 2 || (sel == 2 && q.size() == 3) || (sel == 3 && q.size() == 4)) istat[0] = 1'b1;
            istat[2] |= pe;
            istat[3] |= fe;
        end
        chk_irq();
    endtask

    // Reads out the whole queue against the model
    task automatic drain();
        while (q.size() > 0) begin
            rd(`URX_OFF_STA);
            `CHK("sta", sta_exp(), rdv)
            rd(`URX_OFF_RXD);
            `CHK("rxd", {7'h00, q[0][8:0]}, rdv)
            void'(q.pop_front());
        end
        rd(`URX_OFF_STA);
        `CHK("sta", sta_exp(), rdv)
    endtask

    task automatic results();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_in);
        n_errors++;
        results();
    end

    // Main sequence
    initial begin
        void'($urandom(85));
        repeat (8) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd(`URX_OFF_STA);
        `CHK("sta", 16'h0010, rdv)
        rd(`URX_OFF_BRG);
        `CHK("brg", 16'h0000, rdv)
        rd(8'h3C);
        `CHK("unmapped", 16'h0000, rdv)
        rd(`URX_OFF_RXD);
        `CHK("rxd", 16'h0000, rdv)
        v = 16'($urandom);
        wr(`URX_OFF_BRG, v);
        rd(`URX_OFF_BRG);
        `CHK("brg", v, rdv)
        v = 16'($urandom);
        wr(`URX_OFF_ADMD, v);
        rd(`URX_OFF_ADMD);
        `CHK("admd", v, rdv)
        v = 16'($urandom);
        wr(`URX_OFF_TXD, v);
        #1 `CHK("txload", 1'b1, tx_load_out)
        `CHK("txchar", v[8:0], tx_char_out)
        rd(`URX_OFF_TXD);
        `CHK("txd", 16'h0000, rdv)
        // Divisor of one doubles the bit time
        baud_divisor_value = 1;
        wr(`URX_OFF_BRG, 16'h0001);
        ien = 5'h1F;
        wr(`URX_OFF_IEN, {11'h000, ien});
        wmode(1'b0, 2'b00);
        tx(9'($urandom), 0);
        drain();
        baud_divisor_value = 0;
        wr(`URX_OFF_BRG, 16'h0000);
        // Every format, high speed on the first, one clean and one faulty character
        for (int p = 0; p < 4; p++) begin
            wmode(p == 0, p[1:0]);
            tx(9'($urandom), 0);
            tx(9'($urandom), (p == 0 || p == 3) ? 2 : 1);
            drain();
        end
        // Interrupt thresholds, then overrun, masking and flush
        wmode(1'b0, 2'b00);
        for (int s = 0; s < 4; s++) begin
            sel = s[1:0];
            wsta();
            wr(`URX_OFF_ICLR, 16'h001F);
            istat = 5'h00;
            repeat ((s < 2) ? 1 : s + 1) tx(9'($urandom), 0);
            if (s == 3) begin
                tx(9'($urandom), 0);
                ien = 5'h00;
                wr(`URX_OFF_IEN, 16'h0000);
                chk_irq();
                ien = 5'h1F;
                wr(`URX_OFF_IEN, 16'h001F);
                wsta();
            end
            drain();
        end
        // Address detect with mask F0 and address A5
        sel   = 2'b00;
        address_detect_enable = 1'b1;
        wsta();
        wmode(1'b0, `URX_PD_9N);
        mask  = 8'hF0;
        maddr = 8'hA5;
        wr(`URX_OFF_ADMD, {mask, maddr});
        foreach (adr_seq[i]) tx(adr_seq[i], 0);
        drain();
        // Address detect has no effect in 8-bit format
        wmode(1'b0, 2'b00);
        tx(9'h033, 0);
        drain();
        results();
    end
endmodule
`default_nettype wire
